/* inc/scs_pkg.sv */
// constants, register map and state type of the sync clock select block
// Function
// - open sync falls back to internal, no fault
// - stuck-low sync: fault low, switching stops
// - fault ends via soft-start on release or clock
// - export runs whenever enabled, even dim low
// - export frequency follows active switching source
// - internal source gives about 50% export duty
// - external source gives fixed-width low export pulse
// - power-up waits while pin held low
package scs_pkg;
    localparam int unsigned CLK_MHZ       = 10;
    localparam int unsigned T_OPEN_NS     = 5000;
    localparam int unsigned T_STUCK_NS    = 10000;
    localparam int unsigned T_GUARD_NS    = 500;
    localparam int unsigned T_PULSE_NS    = 200;
    localparam int unsigned T_PULSE_LF_NS = 1000;
    localparam int unsigned OPEN_CYC      = (T_OPEN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned STUCK_CYC     = (T_STUCK_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned GUARD_CYC     = (T_GUARD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PULSE_CYC     = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PULSE_LF_CYC  = (T_PULSE_LF_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W         = 8;
    localparam int unsigned ADR_W         = 4;
    localparam logic [ADR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADR_W-1:0] REG_DIV  = 4'h4;
    localparam logic [ADR_W-1:0] REG_STAT = 4'h8;
    localparam int unsigned CTRL_FORCE_BIT = 0;
    localparam logic [7:0] DIV_RST         = 8'h03;
    localparam int unsigned ST_SRC_BIT     = 0;
    localparam int unsigned ST_FAULT_BIT   = 1;
    localparam int unsigned ST_RUN_BIT     = 2;
    localparam int unsigned ST_OPEN_BIT    = 3;
    localparam int unsigned ST_EN_BIT      = 4;
    localparam int unsigned ST_FORCE_BIT   = 5;
    typedef enum logic [2:0] {ST_OFF, ST_HOLD, ST_INT, ST_EXT, ST_FAULT} scs_state_type;
endpackage

/* inc/scs_edge_if.sv */
// carrier for sync edge events between the crossing and the selector
`timescale 1ns/100ps
interface scs_edge_if;
    logic edge_p;
    modport src (output edge_p);
    modport dst (input  edge_p);
endinterface

/* rtl/scs_edge_xing.sv */
// sync clock edge counter on the link clock, gray crossing to clk_i
`timescale 1ns/100ps
module scs_edge_xing
    import scs_pkg::*;
#(
    parameter int unsigned CW = 4
) (
    input  wire logic link_clk_i,
    input  wire logic clk_i,
    input  wire logic rst_i,
    scs_edge_if.src   edge_if
);
    logic [1:0]    lrst_q;
    logic [CW-1:0] bin_q;
    logic [CW-1:0] gray_q;
    logic [CW-1:0] g1_q;
    logic [CW-1:0] g2_q;
    logic [CW-1:0] g3_q;
    logic          edge_q;

    ////////////////////////////////////////////////////////////////
    // link domain: counts while the sync clock runs, nothing after it stops
    always_ff @(posedge link_clk_i) begin
        lrst_q <= {lrst_q[0], rst_i};
    end

    always_ff @(posedge link_clk_i) begin
        if (lrst_q[1]) begin
            bin_q  <= '0;
            gray_q <= '0;
        end else begin
            bin_q  <= bin_q + 1'b1;
            gray_q <= (bin_q + 1'b1) ^ ((bin_q + 1'b1) >> 1);
        end
    end

    ////////////////////////////////////////////////////////////////
    // clk domain: gray word passes two flops, one bit moves per step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            g1_q   <= '0;
            g2_q   <= '0;
            g3_q   <= '0;
            edge_q <= 1'b0;
        end else begin
            g1_q   <= gray_q;
            g2_q   <= g1_q;
            g3_q   <= g2_q;
            edge_q <= (g2_q != g3_q); // several edges in one cycle merge
        end
    end

    assign edge_if.edge_p = edge_q;
endmodule

/* rtl/scs_clk_select.sv */
// switching clock source select, loss-of-sync watch and timebase export
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module scs_clk_select
    import scs_pkg::*;
#(
    parameter bit LOW_FREQ = 1'b0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             sync_clk_i,
    input  wire logic             en_i,
    input  wire logic             dim_i,
    input  wire logic             pin_open_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  timebase_export_o,
    output logic                  switch_node_o,
    output logic                  fault_n_o,
    output logic                  soft_start_o,
    output logic                  src_ext_o
);
    localparam logic [CNT_W-1:0] OPEN_C  = CNT_W'(OPEN_CYC);
    localparam logic [CNT_W-1:0] STUCK_C = CNT_W'(STUCK_CYC);
    localparam logic [CNT_W-1:0] GUARD_C = CNT_W'(GUARD_CYC);
    localparam logic [CNT_W-1:0] PULSE_C = LOW_FREQ ? CNT_W'(PULSE_LF_CYC) : CNT_W'(PULSE_CYC);

    scs_edge_if    edge_if ();
    scs_state_type state_q;
    scs_state_type state_d;
    logic [2:0]       pin1_q;
    logic [2:0]       pin2_q;
    logic             en_s;
    logic             dim_s;
    logic             open_s;
    logic             dim_prev_q;
    logic [CNT_W-1:0] dim_cnt_q;
    logic             force_q;
    logic             force_act_q;
    logic [7:0]       div_q;
    logic [CNT_W-1:0] gap_q;
    logic [7:0]       osc_cnt_q;
    logic             osc_q;
    logic [CNT_W-1:0] pulse_cnt_q;
    logic             run;
    logic             src_clk;
    logic             req;

    scs_edge_xing #(.CW(4)) u_xing (
        .link_clk_i (sync_clk_i),
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .edge_if    (edge_if)
    );

    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin1_q <= '0;
            pin2_q <= '0;
        end else begin
            pin1_q <= {pin_open_i, dim_i, en_i};
            pin2_q <= pin1_q;
        end
    end
    assign en_s   = pin2_q[0];
    assign dim_s  = pin2_q[1];
    assign open_s = pin2_q[2];

    ////////////////////////////////////////////////////////////////
    // source change request held back near a dim rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dim_prev_q <= 1'b0;
            dim_cnt_q  <= '0;
        end else begin
            dim_prev_q <= dim_s;
            if (dim_s && !dim_prev_q) begin
                dim_cnt_q <= '0;
            end else if (dim_cnt_q != GUARD_C) begin
                dim_cnt_q <= dim_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_act_q <= 1'b0;
        end else if (!dim_s || (dim_cnt_q == GUARD_C && !(dim_s && !dim_prev_q))) begin
            force_act_q <= force_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // loss window: clk_i is the internal timebase, so it keeps running
    // when the sync clock dies
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_q <= '0;
        end else if (edge_if.edge_p) begin
            gap_q <= '0;
        end else if (gap_q != STUCK_C) begin
            gap_q <= gap_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // source state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_OFF: begin
                state_d = ST_HOLD;
            end
            ST_HOLD, ST_FAULT: begin
                if (edge_if.edge_p && !force_act_q) begin
                    state_d = ST_EXT;
                end else if (open_s || edge_if.edge_p) begin
                    state_d = ST_INT;
                end
            end
            ST_INT: begin
                if (edge_if.edge_p && !force_act_q) begin
                    state_d = ST_EXT;
                end else if (!open_s && gap_q == STUCK_C) begin
                    state_d = ST_FAULT;
                end
            end
            ST_EXT: begin
                if (force_act_q) begin
                    state_d = ST_INT;
                end else if (open_s && gap_q >= OPEN_C) begin
                    state_d = ST_INT;
                end else if (!open_s && gap_q == STUCK_C) begin
                    state_d = ST_FAULT;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (!en_s) begin
            state_d = ST_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // internal oscillator, half period set by div_q
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_cnt_q <= '0;
            osc_q     <= 1'b0;
        end else if (osc_cnt_q >= div_q) begin
            osc_cnt_q <= '0;
            osc_q     <= !osc_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 1'b1;
        end
    end

    // fixed low pulse per sync edge, reloaded on every edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_cnt_q <= '0;
        end else if (edge_if.edge_p) begin
            pulse_cnt_q <= PULSE_C;
        end else if (pulse_cnt_q != '0) begin
            pulse_cnt_q <= pulse_cnt_q - 1'b1;
        end
    end

    assign run     = (state_q == ST_INT) || (state_q == ST_EXT);
    assign src_clk = (state_q == ST_EXT) ? (pulse_cnt_q == '0) : osc_q;

    ////////////////////////////////////////////////////////////////
    // pin outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timebase_export_o <= 1'b0;
            switch_node_o     <= 1'b0;
            fault_n_o         <= 1'b1;
            soft_start_o      <= 1'b0;
            src_ext_o         <= 1'b0;
        end else begin
            timebase_export_o <= en_s && src_clk;
            switch_node_o     <= run && dim_s && src_clk;
            fault_n_o         <= (state_q != ST_FAULT);
            soft_start_o      <= ((state_q == ST_HOLD) || (state_q == ST_FAULT))
                                 && ((state_d == ST_INT) || (state_d == ST_EXT));
            src_ext_o         <= (state_q == ST_EXT);
        end
    end

    ////////////////////////////////////////////////////////////////
    // wishbone slave, ack one cycle after the request, unmapped reads zero
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            force_q  <= 1'b0;
            div_q    <= DIV_RST;
        end else begin
            wb_ack_o <= req;
            if (req && wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == REG_CTRL) begin
                    force_q <= wb_dat_i[CTRL_FORCE_BIT];
                end
                if (wb_adr_i == REG_DIV) begin
                    div_q <= wb_dat_i[7:0];
                end
            end
            if (req && !wb_we_i) begin
                wb_dat_o <= '0;
                unique case (wb_adr_i)
                    REG_CTRL: wb_dat_o[CTRL_FORCE_BIT] <= force_q;
                    REG_DIV:  wb_dat_o[7:0] <= div_q;
                    REG_STAT: begin
                        wb_dat_o[ST_SRC_BIT]   <= (state_q == ST_EXT);
                        wb_dat_o[ST_FAULT_BIT] <= (state_q == ST_FAULT);
                        wb_dat_o[ST_RUN_BIT]   <= run;
                        wb_dat_o[ST_OPEN_BIT]  <= open_s;
                        wb_dat_o[ST_EN_BIT]    <= en_s;
                        wb_dat_o[ST_FORCE_BIT] <= force_act_q;
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    logic [8:0]       hi_run_q;
    logic [CNT_W-1:0] lo_run_q;
    logic [1:0]       falls_q;
    logic [4:0]       ext_age_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hi_run_q  <= '0;
            lo_run_q  <= '0;
            falls_q   <= '0;
            ext_age_q <= '0;
        end else begin
            hi_run_q  <= timebase_export_o ? hi_run_q + 1'b1 : '0;
            lo_run_q  <= timebase_export_o ? '0 : lo_run_q + 1'b1;
            if (!en_s || state_q == ST_EXT || $changed(div_q)) begin
                falls_q <= '0;
            end else if ($fell(timebase_export_o) && falls_q != 2'd2) begin
                falls_q <= falls_q + 1'b1;
            end
            if (state_q != ST_EXT) begin
                ext_age_q <= '0;
            end else if (ext_age_q != 5'h1f) begin
                ext_age_q <= ext_age_q + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_open_loss;
        state_q == ST_EXT && en_s && open_s && !force_act_q && gap_q >= OPEN_C;
    endsequence
    sequence s_stuck_loss;
        state_q == ST_EXT && en_s && !open_s && !force_act_q && gap_q == STUCK_C;
    endsequence

    property p_open_fallback;
        s_open_loss |=> (state_q == ST_INT) ##1 fault_n_o;
    endproperty
    a_open_fallback: assert property (p_open_fallback) else $error("open sync no fallback");

    // pin flops lag the state by one cycle, so they are looked at two cycles on
    property p_stuck_fault;
        (s_stuck_loss and !edge_if.edge_p)
            |=> (state_q == ST_FAULT) ##2 (!fault_n_o && !switch_node_o);
    endproperty
    a_stuck_fault: assert property (p_stuck_fault) else $error("stuck sync no fault");

    property p_restart;
        state_q == ST_FAULT && en_s && (open_s || edge_if.edge_p) |=> soft_start_o ##1 fault_n_o;
    endproperty
    a_restart: assert property (p_restart) else $error("fault not left by soft start");

    property p_export_runs;
        en_s && state_q == ST_INT && !dim_s |-> ##[1:600] $changed(timebase_export_o);
    endproperty
    a_export_runs: assert property (p_export_runs) else $error("export idle while enabled");

    property p_follow_ext;
        state_q == ST_EXT && state_d == ST_EXT && edge_if.edge_p |=> ##1 !timebase_export_o;
    endproperty
    a_follow_ext: assert property (p_follow_ext) else $error("export missed sync edge");

    property p_int_duty;
        $fell(timebase_export_o) && falls_q == 2'h2 && state_q == ST_INT
            |-> hi_run_q == {1'b0, div_q} + 9'h001;
    endproperty
    a_int_duty: assert property (p_int_duty) else $error("internal export duty wrong");

    property p_ext_pulse;
        $rose(timebase_export_o) && state_q == ST_EXT && ext_age_q == 5'h1f
            |-> lo_run_q == PULSE_C;
    endproperty
    a_ext_pulse: assert property (p_ext_pulse) else $error("external low pulse width wrong");

    property p_hold_low;
        state_q == ST_HOLD && en_s && !open_s && !edge_if.edge_p |=> state_q == ST_HOLD ##1 !switch_node_o;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("started with pin held low");

    property p_gap_count;
        edge_if.edge_p ##1 (!edge_if.edge_p)[*8] |=> gap_q == 8'h08;
    endproperty
    a_gap_count: assert property (p_gap_count) else $error("loss window count wrong");
endmodule

/* tb/scs_sync_src.sv */
// far-side sync clock source model driving the frequency program pin
`timescale 1ns/100ps
module scs_sync_src (
    input  wire logic fast_i,
    input  wire logic slow_i,
    output logic      sync_o
);
    ////////////////////////////////////////////////////////////////////////
    // stands low between frames, like a shorted or released source
    initial begin
        sync_o = 1'b0;
        forever begin
            if (fast_i) begin
                sync_o = 1'b1;
                #16;
                sync_o = 1'b0;
                #16;
            end else if (slow_i) begin
                sync_o = 1'b1;
                #800;
                sync_o = 1'b0;
                #800;
            end else begin
                sync_o = 1'b0;
                @(fast_i or slow_i);
                // offset keeps sync edges off the system clock edges
                #7;
            end
        end
    end
endmodule

/* tb/scs_clk_select_tb.sv */
// self-checking bench for the sync clock select block
`timescale 1ns/100ps
module scs_clk_select_tb;
    import scs_pkg::*;
    logic             clk_i;
    logic             rst_i;
    logic             sync_clk, fast, slow, en, dim, pin_open;
    logic             cyc, stb, we, ack, exp_o, sw, flt_n, ss, ext;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dw, dr, q;
    logic [3:0]       obs;
    int               fails, n_checks, cyc_cnt, n, k;
    assign obs = {ss, ext, flt_n, sw};

    scs_sync_src src (.fast_i(fast), .slow_i(slow), .sync_o(sync_clk));
    scs_clk_select #(.LOW_FREQ(1'b0)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .sync_clk_i(sync_clk), .en_i(en), .dim_i(dim),
        .pin_open_i(pin_open), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
        .timebase_export_o(exp_o), .switch_node_o(sw), .fault_n_o(flt_n),
        .soft_start_o(ss), .src_ext_o(ext));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // run is well under a thousand cycles; ceiling leaves wide margin
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            fails++;
            close_out;
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] xp);
        n_checks++;
        if (got !== xp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, xp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d; sel <= 4'hf;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dr;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    // waits until obs[b] shows v, at most lim cycles; k counts the cycles
    task automatic wait_bit(input int b, input logic v, input int lim);
        k = 0;
        while (obs[b] !== v && k < lim) begin
            k++;
            @(posedge clk_i);
        end
    endtask

    // length of one complete run of the export at level lvl
    task automatic run_len(input logic lvl);
        n = 0;
        while (exp_o !== ~lvl) @(posedge clk_i);
        while (exp_o !== lvl) @(posedge clk_i);
        while (exp_o === lvl) begin
            n++;
            @(posedge clk_i);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        wb(1'b0, REG_DIV, 32'h0);
        chk("div_reset", q, {24'h0, DIV_RST});
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl_reset", q, 32'h0);
        wb(1'b1, 4'hc, 32'hff);
        wb(1'b0, 4'hc, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b0, REG_STAT, 32'h0);
        chk("status_reset", q, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_hold;
        en <= 1'b1;
        dim <= 1'b1;
        n = 0;
        repeat (150) begin
            @(posedge clk_i);
            if (sw !== 1'b0 || ext !== 1'b0) n++;
        end
        chk("held_off", n, 0);
        slow <= 1'b1;
        wait_bit(3, 1'b1, 80);
        chk("start_pulse", ss, 1'b1);
        wait_bit(2, 1'b1, 5);
        chk("ext_used", ext, 1'b1);
        $display("test hold done");
    endtask

    task automatic t_ext;
        run_len(1'b0);
        chk("ext_low_width", n, PULSE_CYC);
        run_len(1'b1);
        chk("ext_period", (n + PULSE_CYC >= 15 && n + PULSE_CYC <= 17), 1'b1);
        $display("test ext done");
    endtask

    task automatic t_stuck;
        slow <= 1'b0;
        wait_bit(1, 1'b0, 200);
        chk("stuck_time", (k >= 80 && k <= 106), 1'b1);
        @(posedge clk_i);
        chk("stuck_switch", sw, 1'b0);
        pin_open <= 1'b1;
        wait_bit(3, 1'b1, 20);
        chk("restart_pulse", ss, 1'b1);
        @(posedge clk_i);
        chk("fault_cleared", flt_n, 1'b1);
        $display("test stuck done");
    endtask

    task automatic t_int;
        dim <= 1'b0;
        run_len(1'b1);
        chk("int_high", n, 4);
        run_len(1'b0);
        chk("int_low", n, 4);
        chk("dim_low_switch", sw, 1'b0);
        wb(1'b1, REG_DIV, 32'h5);
        run_len(1'b1);
        chk("div5_high", n, 6);
        run_len(1'b0);
        chk("div5_low", n, 6);
        $display("test int done");
    endtask

    task automatic t_open;
        dim <= 1'b1;
        slow <= 1'b1;
        wait_bit(2, 1'b1, 80);
        slow <= 1'b0;
        n = 0;
        k = 0;
        while (ext === 1'b1 && k < 120) begin
            k++;
            if (flt_n !== 1'b1) n++;
            @(posedge clk_i);
        end
        chk("open_time", (k >= 25 && k <= 60), 1'b1);
        chk("open_no_fault", n, 0);
        wait_bit(0, 1'b1, 30);
        chk("open_switching", sw, 1'b1);
        $display("test open done");
    endtask

    task automatic t_force;
        slow <= 1'b1;
        wait_bit(2, 1'b1, 80);
        repeat (10) @(posedge clk_i);
        wb(1'b1, REG_CTRL, 32'h1);
        wb(1'b0, REG_STAT, 32'h0);
        chk("force_applied", q[ST_FORCE_BIT], 1'b1);
        wait_bit(2, 1'b0, 10);
        chk("force_internal", ext, 1'b0);
        dim <= 1'b0;
        wb(1'b1, REG_CTRL, 32'h0);
        slow <= 1'b0;
        en <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("disabled_export", exp_o, 1'b0);
        $display("test force done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1; en = 1'b0; dim = 1'b0; pin_open = 1'b0; fast = 1'b1; slow = 1'b0;
        cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = 4'h0; dw = 32'h0;
        fails = 0; n_checks = 0; cyc_cnt = 0;
        repeat (5) @(posedge clk_i);
        chk("reset_outs", {exp_o, sw, flt_n, ss, ext, ack}, 32'h8);
        rst_i <= 1'b0;
        fast <= 1'b0;
        t_regs;
        t_hold;
        t_ext;
        t_stuck;
        t_int;
        t_open;
        t_force;
        close_out;
    end
endmodule
